// [cdoc_params.svh]
// Constants for the cable driver output control register bank.
// Assumes inclusion by its bare name from the package and the bank module.
`ifndef CDOC_PARAMS_SVH
`define CDOC_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CDOC_REG_STATUS 8'h01
`define CDOC_REG_RATE_PD 8'h02
`define CDOC_REG_LSB 8'h03
`define CDOC_REG_OUT_A 8'h05
`define CDOC_REG_OUT_B_SWING 8'h06
`define CDOC_REG_OUT_B_CTRL 8'h07

// ****************************************************************
// Field positions
// ****************************************************************
`define CDOC_ST_DETECT_BIT 0
`define CDOC_RATE_SD_BIT 7
`define CDOC_PD_B_BIT 6
`define CDOC_PD_A_BIT 5
`define CDOC_LSB_HD_A_BIT 7
`define CDOC_LSB_SD_A_BIT 6
`define CDOC_FORCE_NO_SIG_BIT 6
`define CDOC_FORCE_SIG_BIT 5
`define CDOC_LOSS_PD_BIT 4
`define CDOC_MUTE_SEL_BIT 3
`define CDOC_SD_LIMIT_MSB 2
`define CDOC_SD_LIMIT_LSB 0
`define CDOC_HD_LIMIT_MSB 7
`define CDOC_HD_LIMIT_LSB 5
`define CDOC_SWING_MSB 4
`define CDOC_SWING_LSB 0
`define CDOC_LSB_HD_B_BIT 7
`define CDOC_LSB_SD_B_BIT 6

// ****************************************************************
// Reset values and bits per byte
// ****************************************************************
`define CDOC_RST_RATE_PD 3'h0
`define CDOC_RST_LSB 2'h0
`define CDOC_RST_OUT_A 8'h02
`define CDOC_RST_OUT_B_SWING 8'h90
`define CDOC_RST_OUT_B_CTRL 8'h1a
`define CDOC_RST_PINS 5'h18
`define CDOC_BYTE_BITS 4'h8

`endif

// [cdoc_pkg.sv]
// Types shared by the output control register bank.
// Assumes cdoc_params.svh is on the include path.
`include "cdoc_params.svh"

package cdoc_pkg;

   // ****************************************************************
   // Serial management engine states
   // ****************************************************************
   typedef enum logic [3:0] {
      CDOC_IDLE,
      CDOC_ADDR,
      CDOC_ADDR_ACK,
      CDOC_CMD,
      CDOC_CMD_ACK,
      CDOC_WDATA,
      CDOC_WDATA_ACK,
      CDOC_RDATA,
      CDOC_RACK
   } cdoc_smb_state_type;

endpackage

// [cdoc_sync.sv]
// Three-stage input synchroniser with agreement filter, one lane per bit.
// Assumes inputs are asynchronous to i_mclk; output is a stable level.
`timescale 1ns/10ps
`default_nettype none

module cdoc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] filt_r;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_lane
         always_ff @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
               s1_r[g] <= RST_VAL[g];
               s2_r[g] <= RST_VAL[g];
               s3_r[g] <= RST_VAL[g];
               filt_r[g] <= RST_VAL[g];
            end else if (i_ce) begin
               s1_r[g] <= i_async[g];
               s2_r[g] <= s1_r[g];
               s3_r[g] <= s2_r[g];
               // Take a new level only once two late stages agree
               if (s2_r[g] == s3_r[g]) begin
                  filt_r[g] <= s3_r[g];
               end
            end
         end
      end
   endgenerate

   assign o_sync = filt_r;

endmodule

`default_nettype wire

// [cdoc_regs.sv]
// Output control register bank with its serial management slave.
// Assumes open-drain wiring of the data line outside and a slow serial
// clock, at least eight i_mclk periods per serial clock phase.
`timescale 1ns/10ps
`default_nettype none
`include "cdoc_params.svh"

// Contract
// [R1] Force-no-signal bit makes input look absent
// [R2] Force-present bit blocks mute and offset
// [R3] Status bit shows true detected input
// [R4] Gating clear: powerdown from bits, enable
// [R5] Gating set, enable low: both drivers down
// [R6] Gating set, enable high: no signal powers down
// [R7] Signal present: no mute, no offset
// [R8] Mute-select: 0 offset, 1 mute
// [R9] Output A SD limit bits 2:0, default 0100
// [R10] Output B HD limit bits 7:5, default 1000
// [R11] Output B SD limit bits 2:0 plus 6
// [R12] Output B swing bits 4:0, default 10000
// [R13] Host writes 0 to reserved bit 7
// [R14] Host writes 011 to reserved bits 5:3
// [R15] Rate bit, pin high forces standard rate
// [R16] Per-output powerdown bits, only enable high
// [R17] Output A SD limit low bit elsewhere
// [R18] Fields hold until write, reset to defaults
module cdoc_regs
   import cdoc_pkg::*;
#(
   // Slave address; the value is arbitrary
   parameter logic [6:0] DEV_ADDR = 7'h2c
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_smb_clk,
   input wire logic i_smb_data,
   output logic o_smb_data,
   output logic o_smb_data_oe_n,
   input wire logic i_enable,
   input wire logic i_rate_sel_pin,
   input wire logic i_signal_detect_n,
   output logic o_out_a_powerdown,
   output logic o_out_b_powerdown,
   output logic o_loss_mute,
   output logic o_loss_offset,
   output logic o_rate_is_standard_def,
   output logic [3:0] o_term_limit_a,
   output logic [3:0] o_term_limit_b,
   output logic [4:0] o_out_b_swing
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [4:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic enable_s;
   logic rate_pin_s;
   logic detect_s;

   cdoc_sync #(
      .WIDTH(5),
      .RST_VAL(`CDOC_RST_PINS)
   ) u_sync (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_async({i_smb_clk, i_smb_data, i_enable, i_rate_sel_pin,
                i_signal_detect_n}),
      .o_sync(pins_s)
   );

   assign scl_s = pins_s[4];
   assign sda_s = pins_s[3];
   assign enable_s = pins_s[2];
   assign rate_pin_s = pins_s[1];
   assign detect_s = pins_s[0];

   // ****************************************************************
   // Bus condition detection
   // ****************************************************************
   logic scl_prev_r;
   logic sda_prev_r;
   logic scl_rise;
   logic scl_fall;
   logic start_evt;
   logic stop_evt;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         scl_prev_r <= 1'b1;
         sda_prev_r <= 1'b1;
      end else if (i_ce) begin
         scl_prev_r <= scl_s;
         sda_prev_r <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_prev_r;
   assign scl_fall = ~scl_s & scl_prev_r;
   assign start_evt = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
   assign stop_evt = scl_s & scl_prev_r & ~sda_prev_r & sda_s;

   // ****************************************************************
   // Register storage
   // ****************************************************************
   logic [2:0] rate_pd_r;
   logic [1:0] lsb_r;
   logic [7:0] out_a_signal_loss_ctrl_r;
   logic [7:0] out_b_swing_hd_limit_r;
   logic [7:0] out_b_limit_ctrl_r;
   logic wr_stb_r;
   logic [7:0] wr_addr_r;
   logic [7:0] wr_data_r;
   logic [7:0] rd_data;
   logic [7:0] ptr_r;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         rate_pd_r <= `CDOC_RST_RATE_PD; // [R18]
         lsb_r <= `CDOC_RST_LSB;
         out_a_signal_loss_ctrl_r <= `CDOC_RST_OUT_A;
         out_b_swing_hd_limit_r <= `CDOC_RST_OUT_B_SWING;
         out_b_limit_ctrl_r <= `CDOC_RST_OUT_B_CTRL;
      end else if (i_ce && wr_stb_r) begin
         if (wr_addr_r == `CDOC_REG_RATE_PD) begin
            rate_pd_r <= wr_data_r[7:5]; // [R15] [R16]
         end else if (wr_addr_r == `CDOC_REG_LSB) begin
            lsb_r <= wr_data_r[7:6]; // [R17]
         end else if (wr_addr_r == `CDOC_REG_OUT_A) begin
            // Reserved bit 7 is stored as written
            out_a_signal_loss_ctrl_r <= wr_data_r; // [R13]
         end else if (wr_addr_r == `CDOC_REG_OUT_B_SWING) begin
            out_b_swing_hd_limit_r <= wr_data_r;
         end else if (wr_addr_r == `CDOC_REG_OUT_B_CTRL) begin
            // Reserved bits 5:3 are stored as written
            out_b_limit_ctrl_r <= wr_data_r; // [R14]
         end
      end
   end

   // ****************************************************************
   // Read data selection
   // ****************************************************************
   always_comb begin
      rd_data = 8'h00;
      if (ptr_r == `CDOC_REG_STATUS) begin
         rd_data[`CDOC_ST_DETECT_BIT] = detect_s; // [R3]
      end else if (ptr_r == `CDOC_REG_RATE_PD) begin
         rd_data[7:5] = rate_pd_r;
      end else if (ptr_r == `CDOC_REG_LSB) begin
         rd_data[7:6] = lsb_r;
      end else if (ptr_r == `CDOC_REG_OUT_A) begin
         rd_data = out_a_signal_loss_ctrl_r;
      end else if (ptr_r == `CDOC_REG_OUT_B_SWING) begin
         rd_data = out_b_swing_hd_limit_r;
      end else if (ptr_r == `CDOC_REG_OUT_B_CTRL) begin
         rd_data = out_b_limit_ctrl_r;
      end
   end

   // ****************************************************************
   // Serial management slave
   // ****************************************************************
   cdoc_smb_state_type state_r;
   logic [3:0] cnt_r;
   logic [7:0] shift_r;
   logic rw_r;
   logic mack_r;
   logic sda_low_r;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= CDOC_IDLE;
         cnt_r <= 4'h0;
         shift_r <= 8'h00;
         ptr_r <= 8'h00;
         rw_r <= 1'b0;
         mack_r <= 1'b0;
         sda_low_r <= 1'b0;
         wr_stb_r <= 1'b0;
         wr_addr_r <= 8'h00;
         wr_data_r <= 8'h00;
      end else if (i_ce) begin
         wr_stb_r <= 1'b0;
         if (start_evt) begin
            state_r <= CDOC_ADDR;
            cnt_r <= 4'h0;
            sda_low_r <= 1'b0;
         end else if (stop_evt) begin
            state_r <= CDOC_IDLE;
            sda_low_r <= 1'b0;
         end else begin
            case (state_r)
               CDOC_ADDR, CDOC_CMD, CDOC_WDATA: begin
                  if (scl_rise) begin
                     shift_r <= {shift_r[6:0], sda_s};
                     cnt_r <= cnt_r + 4'h1;
                  end else if (scl_fall && cnt_r == `CDOC_BYTE_BITS) begin
                     cnt_r <= 4'h0;
                     if (state_r == CDOC_ADDR) begin
                        if (shift_r[7:1] == DEV_ADDR) begin
                           rw_r <= shift_r[0];
                           sda_low_r <= 1'b1;
                           state_r <= CDOC_ADDR_ACK;
                        end else begin
                           state_r <= CDOC_IDLE;
                        end
                     end else if (state_r == CDOC_CMD) begin
                        ptr_r <= shift_r;
                        sda_low_r <= 1'b1;
                        state_r <= CDOC_CMD_ACK;
                     end else begin
                        wr_stb_r <= 1'b1;
                        wr_addr_r <= ptr_r;
                        wr_data_r <= shift_r;
                        ptr_r <= ptr_r + 8'h01;
                        sda_low_r <= 1'b1;
                        state_r <= CDOC_WDATA_ACK;
                     end
                  end
               end
               CDOC_ADDR_ACK: begin
                  if (scl_fall) begin
                     if (rw_r) begin
                        shift_r <= rd_data;
                        sda_low_r <= ~rd_data[7];
                        cnt_r <= 4'h0;
                        state_r <= CDOC_RDATA;
                     end else begin
                        sda_low_r <= 1'b0;
                        state_r <= CDOC_CMD;
                     end
                  end
               end
               CDOC_CMD_ACK, CDOC_WDATA_ACK: begin
                  if (scl_fall) begin
                     sda_low_r <= 1'b0;
                     state_r <= CDOC_WDATA;
                  end
               end
               CDOC_RDATA: begin
                  if (scl_fall) begin
                     if (cnt_r == 4'h7) begin
                        sda_low_r <= 1'b0;
                        ptr_r <= ptr_r + 8'h01;
                        state_r <= CDOC_RACK;
                     end else begin
                        shift_r <= {shift_r[6:0], 1'b0};
                        sda_low_r <= ~shift_r[6];
                        cnt_r <= cnt_r + 4'h1;
                     end
                  end
               end
               CDOC_RACK: begin
                  if (scl_rise) begin
                     mack_r <= ~sda_s;
                  end else if (scl_fall) begin
                     if (mack_r) begin
                        shift_r <= rd_data;
                        sda_low_r <= ~rd_data[7];
                        cnt_r <= 4'h0;
                        state_r <= CDOC_RDATA;
                     end else begin
                        state_r <= CDOC_IDLE;
                     end
                  end
               end
               default: begin
                  sda_low_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // Open drain: only ever pull low
   assign o_smb_data = 1'b0;
   assign o_smb_data_oe_n = ~sda_low_r;

   // ****************************************************************
   // Signal loss and power control
   // ****************************************************************
   logic force_no_signal;
   logic force_signal_present;
   logic loss_gated_powerdown;
   logic mute_sel;
   logic signal_seen;
   logic rate_sd;

   assign force_no_signal =
      out_a_signal_loss_ctrl_r[`CDOC_FORCE_NO_SIG_BIT];
   assign force_signal_present =
      out_a_signal_loss_ctrl_r[`CDOC_FORCE_SIG_BIT];
   assign loss_gated_powerdown =
      out_a_signal_loss_ctrl_r[`CDOC_LOSS_PD_BIT];
   assign mute_sel = out_a_signal_loss_ctrl_r[`CDOC_MUTE_SEL_BIT];

   // Forced presence takes priority over forced absence
   assign signal_seen = force_signal_present | // [R2]
                        (~force_no_signal & detect_s); // [R1]

   assign rate_sd = rate_pin_s | rate_pd_r[2]; // [R15]

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_loss_mute <= 1'b0;
         o_loss_offset <= 1'b0;
      end else if (i_ce) begin
         o_loss_mute <= ~signal_seen & mute_sel; // [R7] [R8]
         o_loss_offset <= ~signal_seen & ~mute_sel; // [R7] [R8]
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_out_a_powerdown <= 1'b1;
         o_out_b_powerdown <= 1'b1;
      end else if (i_ce) begin
         // Enable low wins over everything; gating adds loss of signal
         o_out_a_powerdown <= ~enable_s | // [R5]
            rate_pd_r[0] | // [R4] [R16]
            (loss_gated_powerdown & ~signal_seen); // [R6]
         o_out_b_powerdown <= ~enable_s | // [R5]
            rate_pd_r[1] | // [R4] [R16]
            (loss_gated_powerdown & ~signal_seen); // [R6]
      end
   end

   // ****************************************************************
   // Rate, threshold and swing outputs
   // ****************************************************************
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_rate_is_standard_def <= 1'b0;
         o_term_limit_a <= 4'h0;
         o_term_limit_b <= 4'h0;
         o_out_b_swing <= 5'h00;
      end else if (i_ce) begin
         o_rate_is_standard_def <= rate_sd;
         o_term_limit_a <= {out_a_signal_loss_ctrl_r[2:0], // [R9]
                            lsb_r[0]}; // [R17]
         if (rate_sd) begin
            o_term_limit_b <= {out_b_limit_ctrl_r[2:0], // [R11]
                               out_b_limit_ctrl_r[`CDOC_LSB_SD_B_BIT]};
         end else begin
            o_term_limit_b <= {out_b_swing_hd_limit_r[7:5], // [R10]
                               out_b_limit_ctrl_r[`CDOC_LSB_HD_B_BIT]};
         end
         o_out_b_swing <= out_b_swing_hd_limit_r[4:0]; // [R12]
      end
   end

endmodule

`default_nettype wire

// [cdoc_regs_properties.sv]
// Assertion checker bound to the output control register bank.
// Assumes a slow serial clock and no serial traffic while i_ce is low.
`timescale 1ns/10ps
`default_nettype none

module cdoc_regs_chk (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_smb_clk,
   input wire logic o_smb_data_oe_n,
   input wire logic i_enable,
   input wire logic i_rate_sel_pin,
   input wire logic i_signal_detect_n,
   input wire logic o_out_a_powerdown,
   input wire logic o_out_b_powerdown,
   input wire logic o_loss_mute,
   input wire logic o_loss_offset,
   input wire logic o_rate_is_standard_def,
   input wire logic [3:0] o_term_limit_a,
   input wire logic [4:0] o_out_b_swing
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   logic [3:0] age_r;
   logic settled;

   // ********
   // Cycles since reset release, saturating
   // ********
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         age_r <= 4'h0;
      end else if (age_r != 4'hf) begin
         age_r <= age_r + 4'h1;
      end
   end
   assign settled = (age_r == 4'hf);

   // ********
   // Properties
   // ********
   property p_loss_excl; !(o_loss_mute && o_loss_offset); endproperty
   a_loss_excl: assert property (p_loss_excl)
      else $error("mute and offset together");
   property p_enable_off;
      !i_enable [*8] |-> o_out_a_powerdown && o_out_b_powerdown;
   endproperty
   a_enable_off: assert property (p_enable_off)
      else $error("driver up with enable low");
   property p_rate_pin;
      i_rate_sel_pin [*8] |-> o_rate_is_standard_def;
   endproperty
   a_rate_pin: assert property (p_rate_pin)
      else $error("rate pin not obeyed");
   property p_defaults;
      $fell(i_rst) |->
         ##[1:2] (o_term_limit_a == 4'h4 && o_out_b_swing == 5'h10);
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("defaults not loaded");
   property p_oe_edge;
      settled && $changed(o_smb_data_oe_n) |-> !i_smb_clk;
   endproperty
   a_oe_edge: assert property (p_oe_edge)
      else $error("data line moved with clock high");
   property p_field_write;
      settled && ($changed(o_out_b_swing) || $changed(o_term_limit_a))
         |-> !i_smb_clk;
   endproperty
   a_field_write: assert property (p_field_write)
      else $error("field changed outside a write");
   sequence s_quiet;
      (settled && i_ce && i_enable && $stable(i_signal_detect_n)) [*8];
   endsequence
   property p_pd_cause;
      s_quiet ##0 $changed(o_out_a_powerdown) |-> !i_smb_clk;
   endproperty
   a_pd_cause: assert property (p_pd_cause)
      else $error("powerdown changed without cause");
   property p_mute_cause;
      s_quiet ##0 $changed(o_loss_mute) |-> !i_smb_clk;
   endproperty
   a_mute_cause: assert property (p_mute_cause)
      else $error("mute changed without cause");

   c_mute: cover property (o_loss_mute);
   c_one_pd: cover property (o_out_a_powerdown && !o_out_b_powerdown);
   c_ack: cover property ($fell(o_smb_data_oe_n));
endmodule

bind cdoc_regs cdoc_regs_chk i_cdoc_regs_chk (
   .i_mclk, .i_rst, .i_ce, .i_smb_clk, .o_smb_data_oe_n, .i_enable,
   .i_rate_sel_pin, .i_signal_detect_n, .o_out_a_powerdown,
   .o_out_b_powerdown, .o_loss_mute, .o_loss_offset,
   .o_rate_is_standard_def, .o_term_limit_a, .o_out_b_swing
);
`default_nettype wire

// [cdoc_smb_host.sv]
// Serial management host model for the register bank.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/10ps
`default_nettype none

module cdoc_smb_host (
   input wire logic i_mclk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda
);
   logic [6:0] dev_addr = 7'h2c;

   // ********
   // Bus phases, ten clocks each
   // ********
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   task automatic wt;
      repeat (10) @(posedge i_mclk);
   endtask
   task automatic bit_io(input logic b, output logic s);
      o_sda <= b;
      wt();
      o_scl <= 1'b1;
      wt();
      s = i_sda;
      o_scl <= 1'b0;
      wt();
   endtask
   task automatic start;
      o_sda <= 1'b1;
      wt();
      o_scl <= 1'b1;
      wt();
      o_sda <= 1'b0;
      wt();
      o_scl <= 1'b0;
      wt();
   endtask
   task automatic stop;
      o_sda <= 1'b0;
      wt();
      o_scl <= 1'b1;
      wt();
      o_sda <= 1'b1;
      wt();
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d,
                         output logic ok);
      logic k0, k1, k2;
      logic [7:0] v;
      v = d;
      if (a == 8'h05) v[7] = 1'b0;
      if (a == 8'h07) v[5:3] = 3'h3;
      @(posedge i_mclk);
      start();
      send({dev_addr, 1'b0}, k0);
      send(a, k1);
      send(v, k2);
      stop();
      ok = k0 & k1 & k2;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                         output logic ok);
      logic k0, k1, k2, s;
      @(posedge i_mclk);
      start();
      send({dev_addr, 1'b0}, k0);
      send(a, k1);
      start();
      send({dev_addr, 1'b1}, k2);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b1, s);
      stop();
      ok = k0 & k1 & k2;
   endtask
endmodule
`default_nettype wire

// [cdoc_regs_tb_top.sv]
// Self-checking bench for the output control register bank.
// Assumes the bank, its checker and the host model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module cdoc_regs_tb_top;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b1;
   logic rpin = 1'b0;
   logic det = 1'b0;
   logic ce = 1'b1;
   wire scl, hsda, dsda, doe_n, sda, pda, pdb, mute, ofs, sd;
   wire [3:0] lima, limb;
   wire [4:0] swing;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   logic k;
   logic [7:0] v;

   assign sda = hsda & (doe_n | dsda);
   always #5 mclk = ~mclk;

   cdoc_regs #(.DEV_ADDR(7'h2c)) i_cdoc_regs (
      .i_mclk(mclk), .i_rst(rst), .i_ce(ce), .i_smb_clk(scl),
      .i_smb_data(sda), .o_smb_data(dsda), .o_smb_data_oe_n(doe_n),
      .i_enable(en), .i_rate_sel_pin(rpin), .i_signal_detect_n(det),
      .o_out_a_powerdown(pda), .o_out_b_powerdown(pdb),
      .o_loss_mute(mute), .o_loss_offset(ofs),
      .o_rate_is_standard_def(sd), .o_term_limit_a(lima),
      .o_term_limit_b(limb), .o_out_b_swing(swing));
   cdoc_smb_host i_cdoc_smb_host (
      .i_mclk(mclk), .i_sda(sda), .o_scl(scl), .o_sda(hsda));

   // ********
   // Helpers
   // ********
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk_bit(input logic g, input logic e);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t bit %b exp %b", $time, g, e);
      end
   endtask
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t byte %h exp %h", $time, g, e);
      end
   endtask
   task automatic pins(input logic e, input logic r, input logic d);
      @(posedge mclk);
      en <= e;
      rpin <= r;
      det <= d;
      repeat (12) @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_cdoc_smb_host.wr_reg(a, d, k);
      chk_bit(k, 1'b1);
      repeat (8) @(posedge mclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      i_cdoc_smb_host.rd_reg(a, v, k);
      chk_bit(k, 1'b1);
      chk_byte(v, e);
   endtask

   // ********
   // Scenarios
   // ********
   task automatic t_defaults;
      pins(1'b1, 1'b0, 1'b0);
      chk_bit(ofs, 1'b1);
      chk_bit(pda, 1'b0);
      chk_byte({4'h0, lima}, 8'h04);
      chk_byte({4'h0, limb}, 8'h08);
      chk_byte({3'h0, swing}, 8'h10);
      rd(8'h05, 8'h02);
      rd(8'h07, 8'h1a);
   endtask
   task automatic t_loss;
      pins(1'b1, 1'b0, 1'b1);
      chk_bit(mute | ofs, 1'b0);
      wr(8'h05, 8'h0a);
      pins(1'b1, 1'b0, 1'b0);
      chk_bit(mute, 1'b1);
      chk_bit(ofs, 1'b0);
      // Clock enable low freezes the pins and the loss outputs
      @(posedge mclk);
      ce <= 1'b0;
      pins(1'b1, 1'b0, 1'b1);
      chk_bit(mute, 1'b1);
      ce <= 1'b1;
      repeat (8) @(posedge mclk);
      chk_bit(mute | ofs, 1'b0);
   endtask
   task automatic t_force;
      wr(8'h05, 8'h4a);
      pins(1'b1, 1'b0, 1'b1);
      chk_bit(mute, 1'b1);
      rd(8'h01, 8'h01);
      wr(8'h05, 8'h22);
      pins(1'b1, 1'b0, 1'b0);
      chk_bit(mute | ofs, 1'b0);
      rd(8'h01, 8'h00);
      wr(8'h05, 8'h82);
      rd(8'h05, 8'h02);
   endtask
   task automatic t_powerdown;
      logic lg, e, d, p;
      for (int i = 0; i < 16; i++) begin
         {lg, e, d, p} = 4'(i);
         if (i[2:0] == 3'h0) wr(8'h05, {3'h0, lg, 4'h2});
         wr(8'h02, {1'b0, lg & p, p, 5'h0});
         pins(e, 1'b0, d);
         chk_bit(pda, ~e | p | (lg & ~d));
         chk_bit(pdb, ~e | (lg & p) | (lg & ~d));
      end
   endtask
   task automatic t_rate;
      logic s;
      wr(8'h03, 8'h40);
      wr(8'h07, 8'hdd);
      for (int i = 0; i < 4; i++) begin
         s = i[0] | i[1];
         wr(8'h02, {i[1], 7'h0});
         pins(1'b1, i[0], 1'b1);
         chk_bit(sd, s);
         chk_byte({4'h0, limb}, s ? 8'h0b : 8'h09);
         chk_byte({4'h0, lima}, 8'h05);
      end
      rd(8'h03, 8'h40);
   endtask
   task automatic t_regs;
      wr(8'h06, 8'h6b);
      wr(8'h02, 8'h00);
      pins(1'b1, 1'b0, 1'b1);
      chk_byte({3'h0, swing}, 8'h0b);
      chk_byte({4'h0, limb}, 8'h07);
      wr(8'h01, 8'hfe);
      rd(8'h01, 8'h01);
      rd(8'h0c, 8'h00);
      i_cdoc_smb_host.dev_addr = 7'h2d;
      i_cdoc_smb_host.wr_reg(8'h06, 8'h00, k);
      chk_bit(k, 1'b0);
      i_cdoc_smb_host.dev_addr = 7'h2c;
      rd(8'h06, 8'h6b);
      @(posedge mclk);
      rst <= 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      repeat (12) @(posedge mclk);
      chk_byte({3'h0, swing}, 8'h10);
      rd(8'h06, 8'h90);
   endtask

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_total++;
         $display("CHECK FAILED t=%0t timeout", $time);
         tally_and_finish();
      end
   end

   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      repeat (10) @(posedge mclk);
      t_defaults();
      t_loss();
      t_force();
      t_powerdown();
      t_rate();
      t_regs();
      tally_and_finish();
   end
endmodule
`default_nettype wire
